// File: shared/ndef_map_consts.svh
// Offsets, field positions, fixed values and codes of the file address mapper
`ifndef NDEF_MAP_CONSTS_SVH
`define NDEF_MAP_CONSTS_SVH
`define REG_FILESEL   4'h0
`define REG_OFFSET    4'h1
`define REG_LENGTH    4'h2
`define REG_CLASS     4'h3
`define REG_CMD       4'h4
`define REG_DATA      4'h5
`define REG_STATUS    4'h6
`define CMD_READ      2'h1
`define CMD_WRITE     2'h2
`define CMD_INIT      2'h3
`define ST_ERR_RANGE  8
`define ST_ERR_CLASS  9
`define ST_ERR_NOFILE 10
`define ST_BYTE_RDY   11
`define ST_BUSY       12
`define CC_BASE       9'h180
`define LENFIELD_BASE 9'h00c
`define BODY_BASE     9'h010
`define LENFIELD_SIZE 16'h0002
`define CC_FILE_LEN   16'h000f
`define NDEF_FILE_LEN 16'h0172
`define MAP_VERSION   8'h20
`define TLV_TYPE      8'h04
`define TLV_LEN       8'h06
`define NDEF_FILE_ID  16'h0103
`define EMPTY_MSGLEN  16'h0003
`define EMPTY_MSG     24'hd00000
`define CLASS_OK      8'h00
`define INIT_LAST     5'h13
`define INIT_CC_LAST  5'h0e
`endif

// File: shared/ndef_map_pkg.sv
// Types shared by the file address mapper and its bench
package ndef_map_pkg;
   typedef enum logic [1:0] {FILE_NONE, FILE_CC, FILE_NDEF} file_e;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
      logic       wr;
      logic       rd;
   } mem_req_s;
endpackage : ndef_map_pkg

// File: hw/ndef_file_address_mapper.sv
// Select-relative file access mapped onto non-volatile memory
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "ndef_map_consts.svh"
// Contract
// [RQ1] Container file offset zero onward maps linearly from Block 24 start.
// [RQ2] Setup party writes mapping version 0x20 at container offset 0x0002.
// [RQ3] Container offsets 3..4 hold maximum read response length, e.g. 0x003B.
// [RQ4] Container offsets 5..6 hold maximum write data length, e.g. 0x0034.
// [RQ5] TLV type 0x04 at offset 7, length 0x06 at offset 8.
// [RQ6] Setup party writes message file identifier 0x0103 at offsets 9..10.
// [RQ7] Offsets 0x000B..0x000C hold largest message file size, e.g. 0x0032.
// [RQ8] Read access byte at 0x000D, write access byte at 0x000E, both 0x00.
// [RQ9] Message file offsets 0..1 map to physical 0x000C..0x000D length field.
// [RQ10] Message file offset 2 onward maps to physical 0x0010, skipping 0x000E..F.
// [RQ11] One command may span length field and body, or touch either alone.
// [RQ12] Empty message file is length 0x0003 then bytes 0xD00000.
// [RQ13] No interrupt output and no interrupt source logic.
// [RQ14] Write command with class byte other than 0x00 answers an error.
// [RQ15] Reader gives write length 1..248, multiple of sixteen when encrypted.
// [RQ16] Access running past the selected file end errors, memory untouched.
module ndef_file_address_mapper #(
   parameter logic [15:0] MAX_RD_LEN = 16'h003b,
   parameter logic [15:0] MAX_WR_LEN = 16'h0034,
   parameter logic [15:0] MAX_NDEF   = 16'h0032,
   parameter logic [7:0]  RD_ACCESS  = 8'h00,
   parameter logic [7:0]  WR_ACCESS  = 8'h00
)(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   // Register port
   input  wire ndef_map_pkg::reg_req_s regReq,
   output logic [15:0]               regRdata,
   // Memory port, read data one cycle after the strobe is seen
   output ndef_map_pkg::mem_req_s    memReq,
   input  wire logic [7:0]           memRdata
);

   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_RD_REQ, S_RD_WAIT, S_RD_HOLD, S_INIT} state_e;

   state_e                state_q;
   ndef_map_pkg::file_e   fileSel_q;
   logic [15:0]           offset_q;
   logic [7:0]            length_q;
   logic [7:0]            class_q;
   logic [15:0]           curOff_q;
   logic [7:0]            remain_q;
   logic [7:0]            rdByte_q;
   logic [4:0]            initIdx_q;
   logic                  errRange_q;
   logic                  errClass_q;
   logic                  errNoFile_q;
   logic [15:0]           regRdata_q;
   ndef_map_pkg::mem_req_s memReq_q;

   logic                  cmdWr;
   logic                  dataWr;
   logic                  dataRd;
   logic [1:0]            cmdCode;
   logic [15:0]           fileLen;
   logic [16:0]           endOff;
   logic                  badRange;
   logic                  badClass;
   logic                  noFile;
   logic                  cmdGood;
   logic [159:0]          initImage;
   logic [7:0]            initByte;
   logic [8:0]            initAddr;
   logic [15:0]           nextOff;

   // Select-relative offset to physical byte address
   function automatic logic [8:0] mapAddr(input ndef_map_pkg::file_e f, input logic [15:0] off);
      logic [8:0] a;
      a = 9'h000;
      if (f == ndef_map_pkg::FILE_CC)
         a = `CC_BASE + off[8:0]; // RQ1
      else if (off < `LENFIELD_SIZE)
         a = `LENFIELD_BASE + off[8:0]; // RQ9
      else
         a = `BODY_BASE + off[8:0] - 9'(`LENFIELD_SIZE); // RQ10
      return a;
   endfunction : mapAddr

   assign cmdWr   = regReq.wr && regReq.addr == `REG_CMD;
   assign dataWr  = regReq.wr && regReq.addr == `REG_DATA;
   assign dataRd  = regReq.rd && regReq.addr == `REG_DATA;
   assign cmdCode = regReq.wdata[1:0];
   assign fileLen = (fileSel_q == ndef_map_pkg::FILE_CC) ? `CC_FILE_LEN : `NDEF_FILE_LEN;
   assign endOff  = {1'b0, offset_q} + {9'h000, length_q};
   // Zero length is refused as well; the reader is expected to stay in range
   assign badRange = length_q == 8'h00 || endOff > {1'b0, fileLen}; // RQ16 RQ15
   assign badClass = cmdCode == `CMD_WRITE && class_q != `CLASS_OK; // RQ14
   assign noFile   = fileSel_q == ndef_map_pkg::FILE_NONE;
   assign cmdGood  = !badRange && !badClass && !noFile;
   assign nextOff  = curOff_q + 16'h0001;

   // Factory image: container file, then an empty message file
   assign initImage = {`CC_FILE_LEN, `MAP_VERSION, // RQ2
                       MAX_RD_LEN, // RQ3
                       MAX_WR_LEN, // RQ4
                       `TLV_TYPE, `TLV_LEN, // RQ5
                       `NDEF_FILE_ID, // RQ6
                       MAX_NDEF, // RQ7
                       RD_ACCESS, WR_ACCESS, // RQ8
                       `EMPTY_MSGLEN, `EMPTY_MSG}; // RQ12
   assign initByte  = initImage[{5'(`INIT_LAST - initIdx_q), 3'b000} +: 8];
   assign initAddr  = (initIdx_q <= `INIT_CC_LAST)
                    ? mapAddr(ndef_map_pkg::FILE_CC, {11'h000, initIdx_q})
                    : mapAddr(ndef_map_pkg::FILE_NDEF,
                              {11'h000, 5'(initIdx_q - `INIT_CC_LAST - 5'h01)});

   // Setup registers; ignored while a transfer runs
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         fileSel_q <= ndef_map_pkg::FILE_NONE;
         offset_q  <= 16'h0000;
         length_q  <= 8'h00;
         class_q   <= 8'h00;
      end
      else if (regReq.wr && state_q == S_IDLE)
      begin
         unique case (regReq.addr)
            `REG_FILESEL: fileSel_q <= ndef_map_pkg::file_e'(regReq.wdata[1:0]);
            `REG_OFFSET:  offset_q  <= regReq.wdata;
            `REG_LENGTH:  length_q  <= regReq.wdata[7:0];
            `REG_CLASS:   class_q   <= regReq.wdata[7:0];
            default:      ;
         endcase
      end
   end

   // Error flags are replaced by each read or write command, cleared otherwise only by reset
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         errRange_q  <= 1'b0;
         errClass_q  <= 1'b0;
         errNoFile_q <= 1'b0;
      end
      else if (cmdWr && state_q == S_IDLE && cmdCode != `CMD_INIT && cmdCode != 2'h0)
      begin
         errNoFile_q <= noFile;
         errClass_q  <= badClass; // RQ14
         errRange_q  <= !noFile && badRange; // RQ16
      end
   end

   // Transfer engine; each byte is mapped on its own so a span may cross the seam
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         state_q   <= S_IDLE;
         curOff_q  <= 16'h0000;
         remain_q  <= 8'h00;
         rdByte_q  <= 8'h00;
         initIdx_q <= 5'h00;
         memReq_q  <= '0;
      end
      else
      begin
         memReq_q.wr <= 1'b0;
         memReq_q.rd <= 1'b0;
         unique case (state_q)
            S_IDLE:
               if (cmdWr && cmdCode == `CMD_INIT)
               begin
                  initIdx_q <= 5'h00;
                  state_q   <= S_INIT;
               end
               else if (cmdWr && cmdGood && cmdCode == `CMD_WRITE)
               begin
                  curOff_q <= offset_q;
                  remain_q <= length_q;
                  state_q  <= S_WRITE;
               end
               else if (cmdWr && cmdGood && cmdCode == `CMD_READ)
               begin
                  curOff_q      <= offset_q;
                  remain_q      <= length_q;
                  memReq_q.rd   <= 1'b1;
                  memReq_q.addr <= mapAddr(fileSel_q, offset_q);
                  state_q       <= S_RD_REQ;
               end
            S_WRITE:
               if (dataWr)
               begin
                  memReq_q.wr   <= 1'b1;
                  memReq_q.addr <= mapAddr(fileSel_q, curOff_q); // RQ11
                  memReq_q.data <= regReq.wdata[7:0];
                  curOff_q      <= nextOff;
                  remain_q      <= remain_q - 8'h01;
                  if (remain_q == 8'h01)
                     state_q <= S_IDLE;
               end
            S_RD_REQ:
               state_q <= S_RD_WAIT;
            S_RD_WAIT:
            begin
               rdByte_q <= memRdata;
               state_q  <= S_RD_HOLD;
            end
            S_RD_HOLD:
               if (dataRd)
               begin
                  curOff_q <= nextOff;
                  remain_q <= remain_q - 8'h01;
                  if (remain_q == 8'h01)
                     state_q <= S_IDLE;
                  else
                  begin
                     memReq_q.rd   <= 1'b1;
                     memReq_q.addr <= mapAddr(fileSel_q, nextOff); // RQ11
                     state_q       <= S_RD_REQ;
                  end
               end
            S_INIT:
            begin
               memReq_q.wr   <= 1'b1;
               memReq_q.addr <= initAddr;
               memReq_q.data <= initByte; // RQ12
               initIdx_q     <= initIdx_q + 5'h01;
               if (initIdx_q == `INIT_LAST)
                  state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         regRdata_q <= 16'h0000;
      else if (!regReq.rd)
         regRdata_q <= 16'h0000;
      else
      begin
         unique case (regReq.addr)
            `REG_FILESEL: regRdata_q <= {14'h0000, fileSel_q};
            `REG_OFFSET:  regRdata_q <= offset_q;
            `REG_LENGTH:  regRdata_q <= {8'h00, length_q};
            `REG_CLASS:   regRdata_q <= {8'h00, class_q};
            `REG_DATA:    regRdata_q <= {8'h00, (state_q == S_RD_HOLD) ? rdByte_q : 8'h00};
            `REG_STATUS:  regRdata_q <= {3'h0, state_q != S_IDLE, state_q == S_RD_HOLD,
                                         errNoFile_q, errClass_q, errRange_q, remain_q};
            default:      regRdata_q <= 16'h0000;
         endcase
      end
   end

   // Nothing here raises an interrupt; only register and memory ports leave
   assign regRdata = regRdata_q; // RQ13
   assign memReq   = memReq_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   logic idleCmd;
   assign idleCmd = cmdWr && state_q == S_IDLE;

   cc_map_a: assert property ( // RQ1
      idleCmd && cmdGood && cmdCode == `CMD_READ && fileSel_q == ndef_map_pkg::FILE_CC
      |=> memReq.rd && memReq.addr == `CC_BASE + $past(offset_q[8:0]))
      else $error("container read mapped wrong");

   lenfield_map_a: assert property ( // RQ9
      idleCmd && cmdGood && cmdCode == `CMD_READ && fileSel_q == ndef_map_pkg::FILE_NDEF
      && offset_q < `LENFIELD_SIZE
      |=> memReq.rd && memReq.addr == `LENFIELD_BASE + $past(offset_q[8:0]))
      else $error("length field mapped wrong");

   body_map_a: assert property ( // RQ10
      idleCmd && cmdGood && cmdCode == `CMD_READ && fileSel_q == ndef_map_pkg::FILE_NDEF
      && offset_q >= `LENFIELD_SIZE
      |=> memReq.rd && memReq.addr == $past(offset_q[8:0]) + 9'h00e)
      else $error("message body mapped wrong");

   seam_cross_a: assert property ( // RQ11
      state_q == S_WRITE && dataWr && fileSel_q == ndef_map_pkg::FILE_NDEF
      && curOff_q == 16'h0001 && remain_q > 8'h01
      |=> memReq.wr && memReq.addr == 9'h00d && state_q == S_WRITE && curOff_q == 16'h0002)
      else $error("seam not crossed to body");

   seam_body_a: assert property ( // RQ11
      state_q == S_WRITE && dataWr && fileSel_q == ndef_map_pkg::FILE_NDEF
      && curOff_q == 16'h0002 |=> memReq.wr && memReq.addr == `BODY_BASE)
      else $error("first body byte mapped wrong");

   class_err_a: assert property ( // RQ14
      idleCmd && cmdCode == `CMD_WRITE && class_q != `CLASS_OK
      |=> errClass_q && state_q == S_IDLE ##1 !memReq.wr)
      else $error("bad class not refused");

   range_err_a: assert property ( // RQ16
      idleCmd && !noFile && badRange && cmdCode != `CMD_INIT && cmdCode != 2'h0
      |=> errRange_q && state_q == S_IDLE ##0 !memReq.wr [*2])
      else $error("range overrun not refused");

   // Init bytes show on the memory port two edges after the command edge
   init_cc_a: assert property ( // RQ3
      idleCmd && cmdCode == `CMD_INIT |=> ##1 memReq.addr == `CC_BASE
      ##3 memReq.wr && memReq.addr == 9'h183 && memReq.data == MAX_RD_LEN[15:8])
      else $error("container image wrong");

   init_tlv_a: assert property ( // RQ5
      idleCmd && cmdCode == `CMD_INIT
      |-> ##9 memReq.data == `TLV_TYPE ##1 memReq.data == `TLV_LEN)
      else $error("TLV header wrong");

   init_empty_a: assert property ( // RQ12
      idleCmd && cmdCode == `CMD_INIT |-> ##18 memReq.addr == 9'h00d
      && memReq.data == 8'h03 ##1 memReq.addr == `BODY_BASE && memReq.data == 8'hd0)
      else $error("empty message image wrong");

   read_data_a: assert property (
      state_q == S_RD_HOLD && dataRd |=> regRdata == {8'h00, $past(rdByte_q)})
      else $error("read byte not returned");

   init_last_a: assert property ( // RQ12
      idleCmd && cmdCode == `CMD_INIT |-> ##21 memReq.wr && memReq.addr == 9'h012
      && memReq.data == 8'h00 && state_q == S_IDLE)
      else $error("init not finished in time");

   nofile_err_a: assert property (
      idleCmd && noFile && (cmdCode == `CMD_READ || cmdCode == `CMD_WRITE)
      |=> errNoFile_q && !errRange_q && state_q == S_IDLE)
      else $error("missing file not refused");

   rdata_idle_a: assert property (
      !regReq.rd |=> regRdata == 16'h0000)
      else $error("read data held past its cycle");

   rd_pulse_a: assert property (
      memReq.rd |=> !memReq.rd)
      else $error("read strobe longer than a cycle");

   busy_hold_a: assert property (
      state_q != S_IDLE && regReq.wr && regReq.addr == `REG_OFFSET
      |=> offset_q == $past(offset_q))
      else $error("setup changed while busy");

   err_clear_a: assert property ( // RQ16
      idleCmd && cmdGood && cmdCode == `CMD_READ
      |=> !errRange_q && !errClass_q && !errNoFile_q && state_q == S_RD_REQ)
      else $error("accepted read left an error set");

   cross_read_c: cover property (
      state_q == S_RD_HOLD && dataRd && curOff_q == 16'h0001 && remain_q > 8'h01);
   init_done_c:  cover property (state_q == S_INIT && initIdx_q == `INIT_LAST);
   class_err_c:  cover property (idleCmd && badClass);
   range_err_c:  cover property (idleCmd && badRange && !noFile);
   seam_write_c: cover property (state_q == S_WRITE && dataWr && curOff_q == 16'h0001);

endmodule : ndef_file_address_mapper

// File: testbench/nvm_model.sv
// Byte-wide non-volatile memory model behind the mapper
`timescale 1ns/1ns
module nvm_model (
   // Clock
   input  wire logic                  mclk,
   // Memory port
   input  wire ndef_map_pkg::mem_req_s memReq,
   output logic [7:0]                 memRdata
);
   logic [7:0] mem [0:511];
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = 8'hff;
      memRdata = 8'h00;
   end
   // Data stand one cycle only; a late capture then sees a changed value
   always @(posedge mclk)
   begin
      if (memReq.rd)
         memRdata <= mem[memReq.addr];
      else
         memRdata <= ~memRdata;
      if (memReq.wr)
         mem[memReq.addr] <= memReq.data;
   end
endmodule : nvm_model

// File: testbench/test_ndef_file_address_mapper.sv
// Register-level bench of the file address mapper
`timescale 1ns/1ns
`include "ndef_map_consts.svh"
module test_ndef_file_address_mapper;
   logic                   mclk;
   logic                   nrst;
   ndef_map_pkg::reg_req_s regReq;
   logic [15:0]            regRdata;
   ndef_map_pkg::mem_req_s memReq;
   logic [7:0]             memRdata;
   logic [15:0]            v;
   logic [7:0]             b;
   int                     num_errors;
   int                     checked;
   int                     cycles;
   logic [7:0] ccImg [0:14] = '{8'h00, 8'h0f, 8'h20, 8'h00, 8'h3b, 8'h00, 8'h34, 8'h04,
                                8'h06, 8'h01, 8'h03, 8'h00, 8'h32, 8'h00, 8'h00};
   logic [7:0] msgImg [0:4] = '{8'h00, 8'ha5, 8'h5a, 8'h00, 8'h00};

   ndef_file_address_mapper dut (.mclk(mclk), .nrst(nrst), .regReq(regReq),
                                 .regRdata(regRdata), .memReq(memReq), .memRdata(memRdata));
   nvm_model nvm (.mclk(mclk), .memReq(memReq), .memRdata(memRdata));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic stop_test;
      $display("Errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   // Bounds a hang in any polling loop
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      regReq <= '0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      regReq <= '0;
      @(negedge mclk);
      d = regRdata;
   endtask : rd

   task automatic access(input logic [1:0] f, input logic [15:0] off, input logic [7:0] len,
                         input logic [7:0] cls, input logic [1:0] c);
      wr(`REG_FILESEL, {14'h0000, f});
      wr(`REG_OFFSET, off);
      wr(`REG_LENGTH, {8'h00, len});
      wr(`REG_CLASS, {8'h00, cls});
      wr(`REG_CMD, {14'h0000, c});
   endtask : access

   task automatic getByte(output logic [7:0] d);
      int n;
      n = 0;
      rd(`REG_STATUS, v);
      while (v[`ST_BYTE_RDY] !== 1'b1 && n < 30)
      begin
         rd(`REG_STATUS, v);
         n++;
      end
      rd(`REG_DATA, v);
      d = v[7:0];
   endtask : getByte

   task automatic errChk(input logic [2:0] e);
      rd(`REG_STATUS, v);
      check({13'h0000, v[10:8]}, {13'h0000, e});
   endtask : errChk

   initial
   begin
      nrst = 1'b0;
      regReq = '0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      rd(`REG_STATUS, v);
      check(v, 16'h0000);
      rd(4'h9, v);
      check(v, 16'h0000);
      // Init image carries version 0x20 and file id 0x0103
      wr(`REG_CMD, 16'h0003);
      wr(`REG_OFFSET, 16'h0055);
      repeat (25) @(negedge mclk);
      for (int i = 0; i < 15; i++)
         check(nvm.mem[9'h180 + i], ccImg[i]);
      check({nvm.mem[9'h00c], nvm.mem[9'h00d]}, 16'h0003);
      check({nvm.mem[9'h010], nvm.mem[9'h011]}, 16'hd000);
      check(nvm.mem[9'h012], 8'h00);
      // A setup write while the image goes out must have been dropped
      rd(`REG_OFFSET, v);
      check(v, 16'h0000);
      access(2'h1, 16'h0000, 8'h0f, 8'h00, `CMD_READ);
      for (int i = 0; i < 15; i++)
      begin
         getByte(b);
         check(b, ccImg[i]);
      end
      // Two bytes straddling the gap between length field and body
      access(2'h2, 16'h0001, 8'h02, 8'h00, `CMD_WRITE);
      wr(`REG_DATA, 16'h00a5);
      wr(`REG_DATA, 16'h005a);
      repeat (3) @(negedge mclk);
      check(nvm.mem[9'h00d], 8'ha5);
      check({nvm.mem[9'h00e], nvm.mem[9'h00f]}, 16'hffff);
      check(nvm.mem[9'h010], 8'h5a);
      access(2'h2, 16'h0000, 8'h05, 8'h00, `CMD_READ);
      for (int i = 0; i < 5; i++)
      begin
         getByte(b);
         check(b, msgImg[i]);
      end
      access(2'h2, 16'h0002, 8'h01, 8'h01, `CMD_WRITE);
      // Data offered to a refused command must not land
      wr(`REG_DATA, 16'h00ee);
      errChk(3'b010);
      check(nvm.mem[9'h010], 8'h5a);
      access(2'h2, 16'h0171, 8'h02, 8'h00, `CMD_WRITE);
      wr(`REG_DATA, 16'h00ee);
      errChk(3'b001);
      check(nvm.mem[9'h17f], 8'hff);
      access(2'h1, 16'h000e, 8'h02, 8'h00, `CMD_READ);
      errChk(3'b001);
      access(2'h1, 16'h0000, 8'h00, 8'h00, `CMD_READ);
      errChk(3'b001);
      access(2'h0, 16'h0000, 8'h01, 8'h00, `CMD_READ);
      errChk(3'b100);
      // Last container byte is still reachable
      access(2'h1, 16'h000e, 8'h01, 8'h00, `CMD_READ);
      errChk(3'b000);
      getByte(b);
      check(b, 8'h00);
      stop_test();
   end
endmodule : test_ndef_file_address_mapper
